// ### cpu_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module cpu_core_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic auto_i,
    input wire logic irq_req_i,
    input wire logic [3:0] new_mask_i,
    output logic irq_ack_o,
    output logic [3:0] mask_o
);
    // accepts a request and loads the mask it carries
    always_ff @(posedge clk_i) begin
        irq_ack_o <= !rst_i && auto_i && irq_req_i && !irq_ack_o;
        if (rst_i) begin
            mask_o <= 4'h0;
        end else if (auto_i && irq_req_i && !irq_ack_o) begin
            mask_o <= new_mask_i;
        end
    end
endmodule : cpu_core_model
`default_nettype wire

// ### priority_interrupt_unit.sv
`timescale 1ns/100ps
`default_nettype none
module priority_interrupt_unit (
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // pins
    input wire logic nmi_i,
    input wire logic [7:0] ext_request_pins_n_i,
    output logic onchip_irq_notify_out_n_o,
    // on-chip sources
    input wire logic break_req_i,
    input wire logic [47:0] periph_req_i,
    // cpu side
    input wire logic [3:0] cpu_mask_level_i,
    input wire logic irq_ack_i,
    output logic irq_req_o,
    output logic [4:0] irq_level_o,
    output logic [7:0] irq_vector_o,
    output logic [3:0] new_mask_o
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic nmi_s1_q;
    logic nmi_s2_q;
    logic nmi_prev_q;
    logic [7:0] ext_s1_q;
    logic [7:0] ext_s2_q;
    logic [7:0] ext_prev_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nmi_s1_q <= 1'b0;
            nmi_s2_q <= 1'b0;
            nmi_prev_q <= 1'b0;
            ext_s1_q <= 8'hFF;
            ext_s2_q <= 8'hFF;
            ext_prev_q <= 8'hFF;
        end else begin
            nmi_s1_q <= nmi_i;
            nmi_s2_q <= nmi_s1_q;
            nmi_prev_q <= nmi_s2_q;
            ext_s1_q <= ext_request_pins_n_i;
            ext_s2_q <= ext_s1_q;
            ext_prev_q <= ext_s2_q;
        end
    end

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [15:0] pri_q [5];
    logic nmi_edge_q;
    logic [7:0] sense_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [27:0] idx;
    logic hit;
    logic [2:0] sel_reg;
    logic [15:0] rd_val;
    logic [15:0] be_mask;
    logic wr_en;
    logic [5:0] wr_hit;

    assign idx = adr_i[29:2];

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    always_comb begin
        hit = 1'b0;
        sel_reg = 3'h0;
        // aliases: bits 23 to 9 of the index do not take part
        if (idx[27:24] == priority_interrupt_unit_pkg::AREA_BITS) begin
            if (idx[8:0] == priority_interrupt_unit_pkg::IDX_PRI_A[8:0]) begin
                hit = 1'b1;
                sel_reg = 3'h0;
            end else if (idx[8:0] == priority_interrupt_unit_pkg::IDX_PRI_B[8:0]) begin
                hit = 1'b1;
                sel_reg = 3'h1;
            end else if (idx[8:0] == priority_interrupt_unit_pkg::IDX_PRI_C[8:0]) begin
                hit = 1'b1;
                sel_reg = 3'h2;
            end else if (idx[8:0] == priority_interrupt_unit_pkg::IDX_PRI_D[8:0]) begin
                hit = 1'b1;
                sel_reg = 3'h3;
            end else if (idx[8:0] == priority_interrupt_unit_pkg::IDX_PRI_E[8:0]) begin
                hit = 1'b1;
                sel_reg = 3'h4;
            end else if (idx[8:0] == priority_interrupt_unit_pkg::IDX_SENSE[8:0]) begin
                hit = 1'b1;
                sel_reg = 3'h5;
            end
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb begin
        rd_val = 16'h0000;
        case (sel_reg)
            3'h0: begin
                rd_val = pri_q[0];
            end
            3'h1: begin
                rd_val = pri_q[1];
            end
            3'h2: begin
                rd_val = pri_q[2];
            end
            3'h3: begin
                rd_val = pri_q[3];
            end
            3'h4: begin
                rd_val = pri_q[4];
            end
            3'h5: begin
                rd_val = {7'h00, nmi_edge_q, sense_q};
                rd_val[priority_interrupt_unit_pkg::NMI_LEVEL_BIT] = nmi_s2_q;
            end
            default: begin
                rd_val = 16'h0000;
            end
        endcase
    end

    // ------------------------------------------------------------
    // write path
    // ------------------------------------------------------------
    assign be_mask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
    assign wr_en = cyc_i && stb_i && we_i && ack_q && hit;

    // one write strobe per register
    always_comb begin
        wr_hit = 6'h00;
        if (wr_en) begin
            wr_hit[sel_reg] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    // bus handshake, one wait cycle then ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q <= cyc_i && stb_i && !ack_q;
            if (cyc_i && stb_i && !ack_q) begin
                rdata_q <= hit ? {16'h0000, rd_val} : 32'h00000000;
            end
        end
    end

    assign ack_o = ack_q;
    assign dat_o = rdata_q;

    // ------------------------------------------------------------
    // priority registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int r = 0; r < 5; r++) begin
                pri_q[r] <= priority_interrupt_unit_pkg::PRI_RESET;
            end
        end else begin
            for (int r = 0; r < 5; r++) begin
                if (wr_hit[r]) begin
                    pri_q[r] <= (pri_q[r] & ~be_mask) | (dat_i[15:0] & be_mask);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // sense control
    // ------------------------------------------------------------
    // sense control, level bit is read only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nmi_edge_q <= 1'b0;
            sense_q <= 8'h00;
        end else if (wr_hit[5]) begin
            if (sel_i[1]) begin
                nmi_edge_q <= dat_i[priority_interrupt_unit_pkg::NMI_EDGE_BIT];
            end
            if (sel_i[0]) begin
                sense_q <= dat_i[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // request detection
    // ------------------------------------------------------------
    logic nmi_pend_q;
    logic [7:0] ext_edge_q;
    logic nmi_edge_seen;
    logic [7:0] ext_fall;
    logic [7:0] ext_active;
    logic [5:0] win_q;
    logic win_valid_q;
    logic ack_nmi;
    logic [7:0] ack_ext;

    // ------------------------------------------------------------
    // edge detect
    // ------------------------------------------------------------
    // rising edge when select is set, falling otherwise
    assign nmi_edge_seen = nmi_edge_q ? (nmi_s2_q && !nmi_prev_q) : (!nmi_s2_q && nmi_prev_q);
    assign ext_fall = ext_prev_q & ~ext_s2_q;
    assign ack_nmi = irq_ack_i && win_valid_q && win_q == 6'(priority_interrupt_unit_pkg::SRC_NMI);

    always_comb begin
        for (int k = 0; k < priority_interrupt_unit_pkg::NUM_EXT; k++) begin
            ack_ext[k] = irq_ack_i && win_valid_q && win_q == 6'(priority_interrupt_unit_pkg::SRC_EXT0 + k);
        end
    end

    // ------------------------------------------------------------
    // nmi latch
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nmi_pend_q <= 1'b0;
        end else if (nmi_edge_seen) begin
            nmi_pend_q <= 1'b1; // new edge wins over acceptance
        end else if (ack_nmi) begin
            nmi_pend_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // pin edge latches
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_edge_q <= 8'h00;
        end else begin
            for (int k = 0; k < priority_interrupt_unit_pkg::NUM_EXT; k++) begin
                // sense bit k belongs to pin 7-k position order: bit 7 is pin 0
                if (ext_fall[k]) begin
                    ext_edge_q[k] <= 1'b1;
                end else if (ack_ext[k] || !sense_q[7 - k]) begin
                    ext_edge_q[k] <= 1'b0;
                end
            end
        end
    end

    // low level or latched falling edge per pin
    always_comb begin
        for (int k = 0; k < priority_interrupt_unit_pkg::NUM_EXT; k++) begin
            ext_active[k] = sense_q[7 - k] ? ext_edge_q[k] : !ext_s2_q[k];
        end
    end

    // ------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------
    logic [4:0] src_lvl [priority_interrupt_unit_pkg::NUM_SRC];
    logic [priority_interrupt_unit_pkg::NUM_SRC-1:0] src_pend;
    logic [5:0] best;
    logic [4:0] best_lvl;
    logic best_valid;
    logic [7:0] best_vec;
    logic [4:0] win_lvl_q;
    logic win_onchip;

    always_comb begin
        src_lvl[priority_interrupt_unit_pkg::SRC_NMI] = priority_interrupt_unit_pkg::LEVEL_NMI;
        src_lvl[priority_interrupt_unit_pkg::SRC_BRK] = priority_interrupt_unit_pkg::LEVEL_BRK;
        src_pend[priority_interrupt_unit_pkg::SRC_NMI] = nmi_pend_q;
        src_pend[priority_interrupt_unit_pkg::SRC_BRK] = break_req_i;
        for (int k = 0; k < priority_interrupt_unit_pkg::NUM_EXT; k++) begin
            // one field per pin
            src_lvl[priority_interrupt_unit_pkg::SRC_EXT0 + k] = {1'b0, pri_q[k / 4][15 - 4 * (k % 4) -: 4]};
            src_pend[priority_interrupt_unit_pkg::SRC_EXT0 + k] = ext_active[k];
        end
        for (int j = 0; j < priority_interrupt_unit_pkg::NUM_PERIPH; j++) begin
            // one field per module, shared by its four sources
            src_lvl[priority_interrupt_unit_pkg::SRC_PER0 + j] =
                {1'b0, pri_q[2 + (j / 16)][15 - 4 * ((j / 4) % 4) -: 4]};
            src_pend[priority_interrupt_unit_pkg::SRC_PER0 + j] = periph_req_i[j];
        end
    end

    // ------------------------------------------------------------
    // winner search
    // ------------------------------------------------------------
    // strict greater keeps the earliest source on ties
    always_comb begin
        best = 6'h00;
        best_lvl = 5'h00;
        best_valid = 1'b0;
        for (int s = 0; s < priority_interrupt_unit_pkg::NUM_SRC; s++) begin
            // level 0 never takes part
            if (src_pend[s] && src_lvl[s] != 5'h00 && src_lvl[s] > best_lvl) begin
                best = 6'(s);
                best_lvl = src_lvl[s];
                best_valid = 1'b1;
            end
        end
    end

    assign win_onchip = best_valid && best >= 6'(priority_interrupt_unit_pkg::SRC_PER0);

    // ------------------------------------------------------------
    // vector lookup
    // ------------------------------------------------------------
    // one vector per source
    always_comb begin
        if (best == 6'(priority_interrupt_unit_pkg::SRC_NMI)) begin
            best_vec = priority_interrupt_unit_pkg::VEC_NMI;
        end else if (best == 6'(priority_interrupt_unit_pkg::SRC_BRK)) begin
            best_vec = priority_interrupt_unit_pkg::VEC_BRK;
        end else begin
            best_vec = priority_interrupt_unit_pkg::VEC_EXT0 + 8'(best - 6'(priority_interrupt_unit_pkg::SRC_EXT0));
        end
    end

    // ------------------------------------------------------------
    // winner register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            win_q <= 6'h00;
            win_lvl_q <= 5'h00;
            win_valid_q <= 1'b0;
            irq_vector_o <= 8'h00;
        end else begin
            win_q <= best;
            win_lvl_q <= best_lvl;
            win_valid_q <= best_valid;
            irq_vector_o <= best_vec;
        end
    end

    // ------------------------------------------------------------
    // cpu request and notify pin
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            onchip_irq_notify_out_n_o <= 1'b1;
        end else begin
            // peripheral winner drives the pin low
            onchip_irq_notify_out_n_o <= !win_onchip;
        end
    end

    // nmi bypasses the mask compare
    assign irq_req_o = win_valid_q &&
        (win_q == 6'(priority_interrupt_unit_pkg::SRC_NMI) || win_lvl_q > {1'b0, cpu_mask_level_i});
    assign irq_level_o = win_lvl_q;

    // ------------------------------------------------------------
    // mask to load
    // ------------------------------------------------------------
    // mask to load on acceptance
    assign new_mask_o = (win_q == 6'(priority_interrupt_unit_pkg::SRC_NMI)) ? priority_interrupt_unit_pkg::MASK_FIXED : win_lvl_q[3:0];
endmodule : priority_interrupt_unit
`default_nettype wire

// ### priority_interrupt_unit_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module priority_interrupt_unit_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic onchip_irq_notify_out_n_o,
    input wire logic [3:0] cpu_mask_level_i,
    input wire logic irq_req_o,
    input wire logic [4:0] irq_level_o,
    input wire logic [7:0] irq_vector_o,
    input wire logic [3:0] new_mask_o
);
    // ----
    // checks
    // ----
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_ack;
        ack_o ##1 !ack_o;
    endsequence
    AST_ACK_ONE_WAIT: assert property (s_take |=> s_ack)
        else $error("ack timing");
    AST_UNMAPPED_ZERO: assert property (s_take ##0 (!we_i && adr_i[29:26] != 4'h5)
        |-> ##2 dat_o == 32'h0) else $error("unmapped read");
    AST_MASK_LIMIT: assert property (irq_req_o && irq_level_o != 5'h10
        |-> irq_level_o > {1'b0, cpu_mask_level_i}) else $error("mask");
    AST_NMI_ALWAYS: assert property (irq_level_o == 5'h10
        |-> irq_req_o && new_mask_o == 4'hF) else $error("nmi");
    AST_LEVEL_ZERO: assert property (irq_req_o |-> irq_level_o != 5'h00)
        else $error("level zero");
    AST_BREAK: assert property (irq_req_o && irq_vector_o == 8'h0C
        |-> irq_level_o == 5'h0F && new_mask_o == 4'hF) else $error("break");
    AST_NEW_MASK: assert property (irq_req_o && irq_level_o < 5'h0F
        |-> new_mask_o == irq_level_o[3:0]) else $error("new mask");
    AST_NOTIFY: assert property (!onchip_irq_notify_out_n_o |-> irq_vector_o >= 8'h48)
        else $error("notify");
endmodule : priority_interrupt_unit_asserts
bind priority_interrupt_unit priority_interrupt_unit_asserts u_chk (.clk_i(clk_i),
    .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o),
    .ack_o(ack_o), .onchip_irq_notify_out_n_o(onchip_irq_notify_out_n_o),
    .cpu_mask_level_i(cpu_mask_level_i), .irq_req_o(irq_req_o), .irq_level_o(irq_level_o),
    .irq_vector_o(irq_vector_o), .new_mask_o(new_mask_o));
`default_nettype wire

// ### priority_interrupt_unit_pkg.sv
// Function
// - five priority registers give sixteen levels to pins and peripheral sources
// - control register bit 15 reads back the synchronised nmi pin level
// - notify pin goes low while a peripheral source holds the winning request
// - priority registers reset to 0000, control resets 8000 or 0000 by nmi pin
// - decode uses only index bits 27 to 24 and 8 to 0
// - levels run 0 to 16, level 0 masks a source
// - nmi has fixed level 16 and ignores the cpu mask
// - nmi is edge sensed, edge select picks rising or falling
// - accepting nmi sets the cpu mask to 15
// - break request has fixed level 15 and sets the mask to 15
// - each external pin selects low level or falling edge sensing
// - first two priority registers hold one level per external pin
// - accepting a pin or on-chip request sets the mask to its level
// - every peripheral source carries its own vector number
// - last three registers give one level per module, fixed ranking inside
// - after reset every pin and peripheral source sits at level 0
// - equal levels resolve by the fixed default source order
// - the accepted source's vector number is presented to the cpu
package priority_interrupt_unit_pkg;
    // ------------------------------------------------------------
    // register indexes, byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [27:0] IDX_PRI_A = 28'h5FFFF84;
    localparam logic [27:0] IDX_PRI_B = 28'h5FFFF86;
    localparam logic [27:0] IDX_PRI_C = 28'h5FFFF88;
    localparam logic [27:0] IDX_PRI_D = 28'h5FFFF8A;
    localparam logic [27:0] IDX_PRI_E = 28'h5FFFF8C;
    localparam logic [27:0] IDX_SENSE = 28'h5FFFF8E;
    localparam logic [3:0] AREA_BITS = 4'h5;
    // ------------------------------------------------------------
    // reset values and field positions
    // ------------------------------------------------------------
    localparam logic [15:0] PRI_RESET = 16'h0000;
    localparam int NMI_LEVEL_BIT = 15;
    localparam int NMI_EDGE_BIT = 8;
    localparam logic [15:0] SENSE_WR_MASK = 16'h01FF;
    // ------------------------------------------------------------
    // sources, levels and vectors
    // ------------------------------------------------------------
    localparam int NUM_EXT = 8;
    localparam int NUM_FIELDS = 12;
    localparam int NUM_PERIPH = 48;
    localparam int NUM_SRC = 2 + NUM_EXT + NUM_PERIPH;
    localparam int SRC_NMI = 0;
    localparam int SRC_BRK = 1;
    localparam int SRC_EXT0 = 2;
    localparam int SRC_PER0 = 10;
    localparam logic [4:0] LEVEL_NMI = 5'h10;
    localparam logic [4:0] LEVEL_BRK = 5'h0F;
    localparam logic [3:0] MASK_FIXED = 4'hF;
    localparam logic [7:0] VEC_NMI = 8'h0B;
    localparam logic [7:0] VEC_BRK = 8'h0C;
    localparam logic [7:0] VEC_EXT0 = 8'h40;
    localparam logic [7:0] VEC_PER0 = 8'h48;
endpackage : priority_interrupt_unit_pkg

// ### priority_interrupt_unit_test.sv
`timescale 1ns/100ps
`default_nettype none
module priority_interrupt_unit_test;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, nmi = 1'b1;
    logic brk = 1'b0, auto = 1'b0, crst = 1'b1, ack, nout, req, iack;
    logic [31:0] adr = 32'h0, dat = 32'h0, rd, q;
    logic [7:0] pins = 8'hFF, vec;
    logic [47:0] per = 48'h0;
    logic [15:0] pri [5];
    logic [4:0] lvl;
    logic [3:0] nm, msk;
    int err_count = 0, comparisons = 0, seed, i, j;
    always #20 clk_i = ~clk_i;
    priority_interrupt_unit dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(4'h3), .dat_i(dat), .dat_o(rd), .ack_o(ack),
        .nmi_i(nmi), .ext_request_pins_n_i(pins), .onchip_irq_notify_out_n_o(nout),
        .break_req_i(brk), .periph_req_i(per), .cpu_mask_level_i(msk), .irq_ack_i(iack),
        .irq_req_o(req), .irq_level_o(lvl), .irq_vector_o(vec), .new_mask_o(nm));
    cpu_core_model cpu (.clk_i(clk_i), .rst_i(crst), .auto_i(auto), .irq_req_i(req),
        .new_mask_i(nm), .irq_ack_o(iack), .mask_o(msk));
    // ----
    // helpers
    // ----
    function automatic logic [31:0] ra(int k);
        return {2'h0, priority_interrupt_unit_pkg::IDX_PRI_A + 28'(2 * k), 2'h0};
    endfunction : ra
    function automatic logic [3:0] plv(int k);
        return 4'(pri[2 + k / 16] >> (12 - 4 * ((k / 4) % 4)));
    endfunction : plv
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic chk_irq(input logic r, input logic [4:0] l, input logic [7:0] v,
            input logic [3:0] m, input logic n);
        chk("irq_req", 32'(r), 32'(req));
        chk("irq_level", 32'(l), 32'(lvl));
        chk("irq_vector", 32'(v), 32'(vec));
        chk("new_mask", 32'(m), 32'(nm));
        chk("notify", 32'(n), 32'(nout));
    endtask : chk_irq
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask : wt
    task automatic wb(input logic w, input logic [31:0] a, input logic [15:0] d,
            output logic [31:0] r);
        int t;
        t = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {16'h0, d};
        do begin
            @(posedge clk_i);
            t++;
        end while (ack !== 1'b1 && t < 20);
        r = rd;
        if (t >= 20) begin
            err_count++;
        end
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task final_report;
        if (err_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report
    initial begin
        wt(3000);
        err_count++;
        final_report();
    end
    // ----
    // scenarios
    // ----
    initial begin
        seed = 96734;
        wt(6);
        rst_i <= 1'b0;
        crst <= 1'b0;
        for (i = 0; i < 6; i++) begin
            wb(1'b0, ra(i), 16'h0, q);
            chk("reset", (i == 5) ? 32'h8000 : 32'h0, q);
        end
        per <= 48'({$random(seed), $random(seed)}) | 48'h1;
        wt(5);
        chk("masked", 32'h0, 32'(req));
        for (i = 0; i < 5; i++) begin
            pri[i] = 16'($random(seed)) | 16'h1111;
            wb(1'b1, ra(i) ^ 32'h0000A800, pri[i], q);
            wb(1'b0, ra(i), 16'h0, q);
            chk("priority", 32'(pri[i]), q);
        end
        wb(1'b0, 32'h0, 16'h0, q);
        chk("unmapped", 32'h0, q);
        wb(1'b1, ra(5), 16'h7E00, q);
        for (i = 0; i < 8; i++) begin
            j = $unsigned($random(seed)) % 48;
            per <= 48'h1 << j;
            wt(3);
            chk_irq(1'b1, {1'b0, plv(j)}, 8'(72 + j), plv(j), 1'b0);
        end
        for (i = 0; i < 5; i++) begin
            wb(1'b1, ra(i), 16'hFFFF, q);
        end
        per <= 48'h8000_0000_0001;
        wt(3);
        chk_irq(1'b1, 5'h0F, 8'h48, 4'hF, 1'b0);
        pins <= 8'h7F;
        wt(5);
        chk_irq(1'b1, 5'h0F, 8'h47, 4'hF, 1'b1);
        pins <= 8'h7E;
        wt(5);
        chk_irq(1'b1, 5'h0F, 8'h40, 4'hF, 1'b1);
        brk <= 1'b1;
        wt(3);
        chk_irq(1'b1, 5'h0F, 8'h0C, 4'hF, 1'b1);
        nmi <= 1'b0;
        wt(6);
        chk_irq(1'b1, 5'h10, 8'h0B, 4'hF, 1'b1);
        auto <= 1'b1;
        wt(4);
        auto <= 1'b0;
        chk("mask", 32'hF, 32'(msk));
        chk("blocked", 32'h0, 32'(req));
        wb(1'b0, ra(5), 16'h0, q);
        chk("control", 32'h0, q);
        wb(1'b1, ra(5), 16'h0101, q);
        nmi <= 1'b1;
        wt(6);
        chk_irq(1'b1, 5'h10, 8'h0B, 4'hF, 1'b1);
        wb(1'b0, ra(5), 16'h0, q);
        chk("control", 32'h8101, q);
        auto <= 1'b1;
        brk <= 1'b0;
        per <= 48'h0;
        pins <= 8'hFF;
        wt(4);
        auto <= 1'b0;
        crst <= 1'b1;
        wb(1'b1, ra(1), 16'h0053, q);
        crst <= 1'b0;
        pins <= 8'h7F;
        wt(1);
        pins <= 8'hFF;
        wt(6);
        chk_irq(1'b1, 5'h03, 8'h47, 4'h3, 1'b1);
        pins <= 8'hBF;
        wt(5);
        chk_irq(1'b1, 5'h05, 8'h46, 4'h5, 1'b1);
        pins <= 8'hFF;
        wt(5);
        chk_irq(1'b1, 5'h03, 8'h47, 4'h3, 1'b1);
        auto <= 1'b1;
        wt(4);
        chk("mask", 32'h3, 32'(msk));
        chk("taken", 32'h0, 32'(req));
        final_report();
    end
endmodule : priority_interrupt_unit_test
`default_nettype wire
